/* src/phsc_counter.sv */
// Preset high-speed counter with a classic Wishbone register slave
// What this block does
// - Up mode: count edges, zero at high preset
// - Up mode range zero to max; clear zeroes
// - Reset/hold variant adds inputs two and three
// - First configure copies image count and preset
// - Image preset reaches hardware only on instructions or up reach
// - Up high preset outside range raises 37H
// - Any signed value loads into count
// - Three ways to reach the high preset
// - Up reach: clear counts, reload preset, lossless
// - First up reach sets done, high cause
// - Later up reach sets positive wrap cause
// - Events request routine only when enabled
// - Pulse/direction or up/down input assignment
// - Bidirectional low preset below high else 37H
// - Bidirectional full signed range; clear zeroes
// - Bidirectional high reach: flag only, no reload
// - Three ways to reach the low preset
// - Low reach sets low flag and cause
// - Max to min step sets positive wrap
// - Min to max step sets negative wrap
// - Hold input or false rung stops counting
// - External reset edge zeroes the count
// - Direction low counts up, high counts down
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "phsc_params.svh"
module phsc_counter (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  fieldIn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic             wb_ack_o,
	output logic      [31:0] wb_dat_o,
	output logic             intReq
);
	logic [15:0]           accReg, accNext, highReg, highNext;
	logic [15:0]           lowReg, lowNext;
	logic [15:0]           imgAccReg, imgHighReg, imgLowReg;
	phsc_pkg::phsc_flags_t flagsReg, flagsNext;
	phsc_pkg::phsc_state_t stateReg, stateNext;
	phsc_pkg::phsc_mode_t  modeReg;
	logic                  rungReg, ieReg, ackReg, intReqReg;
	logic [7:0]            faultReg;
	logic [31:0]           datReg;
	logic [3:0]            levels, rises;
	logic                  hiHit, loHit, ovf, unf, checkLim, limBad;
	logic                  upReach, reloadBad;

	// Byte-lane merge of a 16-bit register write
	function automatic logic [15:0] laneMerge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		laneMerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : laneMerge

	// Signed greater-or-equal on two's complement words
	function automatic logic sGe(input logic [15:0] a,
		input logic [15:0] b);
		sGe = $signed(a) >= $signed(b);
	endfunction : sGe

	// Field inputs enter through the synchroniser only
	phsc_edge_sync uSync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.fieldIn (fieldIn),
		.levels  (levels),
		.rises   (rises)
	);

	// Wishbone decode; one access answered per request
	wire        busReq  = wb_cyc_i & wb_stb_i & ~ackReg;
	wire        busWr   = busReq & wb_we_i;
	wire [7:0]  adrW    = {wb_adr_i[7:2], 2'b00};
	wire        selCtrl = adrW == `PHSC_ADR_CTRL;
	wire        selCmd  = adrW == `PHSC_ADR_CMD;
	wire        selStat = adrW == `PHSC_ADR_STATUS;
	wire        selIAcc = adrW == `PHSC_ADR_IMG_ACC;
	wire        selIHi  = adrW == `PHSC_ADR_IMG_HIGH;
	wire        selILo  = adrW == `PHSC_ADR_IMG_LOW;
	wire        selHAcc = adrW == `PHSC_ADR_HW_ACC;
	wire        selHHi  = adrW == `PHSC_ADR_HW_HIGH;
	wire        selHLo  = adrW == `PHSC_ADR_HW_LOW;
	wire        selIn   = adrW == `PHSC_ADR_INPUTS;
	wire        wrCtrl  = busWr & selCtrl & wb_sel_i[0];
	wire        wrStat  = busWr & selStat & wb_sel_i[0];

	// Instruction strobes, one cycle each
	wire phsc_pkg::phsc_cmd_t cmd = (busWr & selCmd & wb_sel_i[0]) ?
		phsc_pkg::phsc_cmd_t'(wb_dat_i[3:0]) : 4'h0;
	wire anyCmd = |cmd;

	// Read data selection
	wire [31:0] statWord = {8'h00, faultReg, 5'h00,
		stateReg == phsc_pkg::PHSC_FAULTED,
		stateReg == phsc_pkg::PHSC_ARMED, flagsReg};
	wire [31:0] rdMux =
		selCtrl ? {27'h0, ieReg, rungReg, modeReg} :
		selStat ? statWord :
		selIAcc ? {16'h0, imgAccReg} :
		selIHi  ? {16'h0, imgHighReg} :
		selILo  ? {16'h0, imgLowReg} :
		selHAcc ? {16'h0, accReg} :
		selHHi  ? {16'h0, highReg} :
		selHLo  ? {16'h0, lowReg} :
		selIn   ? {28'h0, levels} : 32'h0;

	// Mode decode
	wire upMode = modeReg == phsc_pkg::PHSC_UP ||
		modeReg == phsc_pkg::PHSC_UP_RH;
	wire pdMode = modeReg == phsc_pkg::PHSC_PD ||
		modeReg == phsc_pkg::PHSC_PD_RH;
	wire udMode = modeReg == phsc_pkg::PHSC_UD ||
		modeReg == phsc_pkg::PHSC_UD_RH;
	wire bidir  = pdMode | udMode;
	wire rhMode = modeReg[0] & (upMode | bidir);
	wire armed  = stateReg == phsc_pkg::PHSC_ARMED;
	wire first  = cmd.counter_config_instr & ~armed;

	// Counting gate: false rung or held input stop counting only
	wire holdOn  = rhMode & levels[`PHSC_IN_HOLD];
	wire countEn = armed & rungReg & ~holdOn;
	wire cntEdge = rises[`PHSC_IN_COUNT];
	wire dirIn   = levels[`PHSC_IN_DIR];
	wire dnEdge  = rises[`PHSC_IN_DIR];
	// Input roles per mode; coincident up and down cancel out
	wire stepUp  = countEn & ((upMode & cntEdge) |
		(pdMode & cntEdge & ~dirIn) |
		(udMode & cntEdge & ~dnEdge));
	wire stepDn  = countEn & ((pdMode & cntEdge & dirIn) |
		(udMode & dnEdge & ~cntEdge));
	wire extClr  = armed & rhMode & rises[`PHSC_IN_RESET];

	// Next count, presets and reach detection
	always_comb begin
		accNext   = accReg;
		highNext  = highReg;
		lowNext   = lowReg;
		checkLim  = 1'b0;
		hiHit     = 1'b0;
		loHit     = 1'b0;
		ovf       = 1'b0;
		unf       = 1'b0;
		limBad    = 1'b0;
		upReach   = 1'b0;
		reloadBad = 1'b0;
		if (first) begin
			accNext  = imgAccReg;
			highNext = imgHighReg;
			lowNext  = imgLowReg;
			checkLim = 1'b1;
		end else if (armed & cmd.counter_clear_instr) begin
			accNext  = `PHSC_WORD_RST;
			if (upMode) begin
				highNext = imgHighReg;
				checkLim = 1'b1;
			end
		end else if (armed & cmd.load_accumulator_instr) begin
			accNext  = imgAccReg;
			if (upMode) begin
				highNext = imgHighReg;
			end
			checkLim = upMode;
			hiHit    = sGe(accNext, highNext);
			loHit    = bidir & sGe(lowReg, accNext);
		end else if (armed & cmd.load_limits_instr) begin
			highNext = imgHighReg;
			lowNext  = imgLowReg;
			checkLim = 1'b1;
			hiHit    = sGe(accReg, highNext);
			loHit    = bidir & sGe(lowNext, accReg);
		end else if (extClr) begin
			accNext = `PHSC_WORD_RST;
		end else if (stepUp) begin
			accNext = accReg + 16'h0001;
			ovf     = accReg == `PHSC_ACC_MAX;
			hiHit   = accNext == highReg;
		end else if (stepDn) begin
			accNext = accReg - 16'h0001;
			unf     = accReg == `PHSC_ACC_MIN;
			loHit   = accNext == lowReg;
		end
		// Preset validity; a bad load keeps count and presets but raises the fault
		if (checkLim) begin
			limBad = upMode ? ~sGe(highNext, `PHSC_UP_HIGH_MIN)
				: (bidir & sGe(lowNext, highNext));
		end
		if (limBad) begin
			accNext  = accReg;
			highNext = highReg;
			lowNext  = lowReg;
			hiHit    = 1'b0;
			loHit    = 1'b0;
		end
		// Up mode reach restarts at zero and takes the image preset
		upReach = upMode & hiHit;
		if (upReach) begin
			accNext   = `PHSC_WORD_RST;
			reloadBad = ~sGe(imgHighReg, `PHSC_UP_HIGH_MIN);
			if (!reloadBad) begin
				highNext = imgHighReg;
			end
		end
	end

	wire evAny    = hiHit | loHit | ovf | unf;
	wire faultSet = limBad | reloadBad;

	// Flags: software clears by writing ones, hardware set wins
	always_comb begin
		flagsNext = flagsReg;
		if (wrStat) begin
			flagsNext[4:0] = flagsReg[4:0] & ~wb_dat_i[4:0];
		end
		if (upReach && !flagsReg.done_flag) begin
			flagsNext.done_flag = 1'b1;
			{flagsNext.cause_negative_wrap, flagsNext.cause_positive_wrap,
			 flagsNext.cause_low_target,
			 flagsNext.cause_high_target} = 4'h1;
		end else if (upReach) begin
			flagsNext.positive_wrap_flag = 1'b1;
			{flagsNext.cause_negative_wrap, flagsNext.cause_positive_wrap,
			 flagsNext.cause_low_target,
			 flagsNext.cause_high_target} = 4'h4;
		end else if (hiHit) begin
			flagsNext.high_target_flag = 1'b1;
			{flagsNext.cause_negative_wrap, flagsNext.cause_positive_wrap,
			 flagsNext.cause_low_target,
			 flagsNext.cause_high_target} = 4'h1;
		end else if (loHit) begin
			flagsNext.low_target_flag = 1'b1;
			{flagsNext.cause_negative_wrap, flagsNext.cause_positive_wrap,
			 flagsNext.cause_low_target,
			 flagsNext.cause_high_target} = 4'h2;
		end
		if (ovf) begin
			flagsNext.positive_wrap_flag = 1'b1;
			{flagsNext.cause_negative_wrap, flagsNext.cause_positive_wrap,
			 flagsNext.cause_low_target,
			 flagsNext.cause_high_target} = 4'h4;
		end else if (unf) begin
			flagsNext.negative_wrap_flag = 1'b1;
			{flagsNext.cause_negative_wrap, flagsNext.cause_positive_wrap,
			 flagsNext.cause_low_target,
			 flagsNext.cause_high_target} = 4'h8;
		end
	end

	// Configuration state
	always_comb begin
		case (stateReg)
			phsc_pkg::PHSC_UNCONF, phsc_pkg::PHSC_FAULTED: begin
				stateNext = stateReg;
				if (first) begin
					stateNext = limBad ? phsc_pkg::PHSC_FAULTED
						: phsc_pkg::PHSC_ARMED;
				end
			end
			phsc_pkg::PHSC_ARMED: begin
				stateNext = faultSet ? phsc_pkg::PHSC_FAULTED
					: phsc_pkg::PHSC_ARMED;
			end
			default: begin
				stateNext = phsc_pkg::PHSC_UNCONF;
			end
		endcase
	end

	// Counter core registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			accReg   <= `PHSC_WORD_RST;
			highReg  <= `PHSC_WORD_RST;
			lowReg   <= `PHSC_WORD_RST;
			flagsReg <= '0;
			stateReg <= phsc_pkg::PHSC_UNCONF;
			faultReg <= `PHSC_FAULT_NONE;
		end else begin
			accReg   <= accNext;
			highReg  <= highNext;
			lowReg   <= lowNext;
			flagsReg <= flagsNext;
			stateReg <= stateNext;
			if (faultSet) begin
				faultReg <= `PHSC_FAULT_PRESETS;
			end else if (first) begin
				faultReg <= `PHSC_FAULT_NONE;
			end
		end
	end

	// Software image and control registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			imgAccReg  <= `PHSC_WORD_RST;
			imgHighReg <= `PHSC_WORD_RST;
			imgLowReg  <= `PHSC_WORD_RST;
			modeReg    <= phsc_pkg::PHSC_UP;
			rungReg    <= 1'b0;
			ieReg      <= 1'b0;
		end else begin
			if (upReach) begin
				imgAccReg <= `PHSC_WORD_RST;
			end else if (busWr & selIAcc) begin
				imgAccReg <= laneMerge(imgAccReg, wb_dat_i, wb_sel_i);
			end
			if (busWr & selIHi) begin
				imgHighReg <= laneMerge(imgHighReg, wb_dat_i, wb_sel_i);
			end
			if (busWr & selILo) begin
				imgLowReg <= laneMerge(imgLowReg, wb_dat_i, wb_sel_i);
			end
			if (wrCtrl) begin
				modeReg <= phsc_pkg::phsc_mode_t'(wb_dat_i[2:0]);
				rungReg <= wb_dat_i[`PHSC_CTRL_RUNG];
			end
			if (first) begin
				ieReg <= 1'b1;
			end else if (wrCtrl) begin
				ieReg <= wb_dat_i[`PHSC_CTRL_IE];
			end
		end
	end

	// Bus answer and routine request, all registered
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ackReg    <= 1'b0;
			datReg    <= 32'h0;
			intReqReg <= 1'b0;
		end else begin
			ackReg    <= busReq;
			datReg    <= (busReq & ~wb_we_i) ? rdMux : 32'h0;
			intReqReg <= evAny & ieReg;
		end
	end

	assign wb_ack_o = ackReg;
	assign wb_dat_o = datReg;
	assign intReq   = intReqReg;

	default clocking cbMain @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence sqUpReach;
		upReach && !reloadBad;
	endsequence
	sequence sqFirstReach;
		upReach && !flagsReg.done_flag;
	endsequence
	sequence sqLaterReach;
		upReach && flagsReg.done_flag;
	endsequence

	chk_up_reach_zero: assert property (
		sqUpReach |=> accReg == 16'h0000 && highReg == $past(imgHighReg)
			&& imgAccReg == 16'h0000)
		else $error("up reach did not restart count");
	chk_up_step_one: assert property (
		upMode && stepUp && !anyCmd && !extClr && !hiHit
		|=> accReg == $past(accReg) + 16'h0001)
		else $error("up edge did not add one");
	chk_clear_zero: assert property (
		armed && cmd.counter_clear_instr && !limBad |=> accReg == 16'h0000)
		else $error("clear left count nonzero");
	chk_cfg_copy: assert property (
		first && !limBad |=> accReg == $past(imgAccReg)
			&& highReg == $past(imgHighReg) && stateReg == phsc_pkg::PHSC_ARMED)
		else $error("configure did not copy images");
	chk_image_only: assert property (
		busWr && selIHi && !anyCmd && !hiHit |=> highReg == $past(highReg))
		else $error("image write reached hardware preset");
	chk_fault_code: assert property (
		limBad |=> faultReg == 8'h37 && stateReg == phsc_pkg::PHSC_FAULTED
			&& accReg == $past(accReg))
		else $error("bad preset not faulted");
	chk_done_first: assert property (
		sqFirstReach |=> flagsReg.done_flag && flagsReg.cause_high_target
			&& !flagsReg.cause_low_target && !flagsReg.cause_positive_wrap)
		else $error("first reach flags wrong");
	chk_wrap_later: assert property (
		sqLaterReach |=> flagsReg.positive_wrap_flag
			&& flagsReg.cause_positive_wrap && !flagsReg.cause_high_target)
		else $error("second reach flags wrong");
	chk_irq_gate: assert property (
		evAny ##1 1 |-> intReq == $past(ieReg) ##1 !intReq || $past(evAny))
		else $error("routine request not gated");
	chk_bidir_keep: assert property (
		bidir && hiHit |=> accReg == $past(accNext)
			&& flagsReg.high_target_flag && flagsReg.cause_high_target)
		else $error("bidirectional reach altered count");
	chk_hold_freeze: assert property (
		(holdOn || !rungReg) && !anyCmd && !extClr |=> $stable(accReg))
		else $error("count moved while held");
	chk_ext_clear: assert property (
		extClr && !anyCmd |=> accReg == 16'h0000)
		else $error("external reset did not clear");
	chk_wrap_pos: assert property (
		ovf |=> accReg == 16'h8000 && flagsReg.positive_wrap_flag
			&& flagsReg.cause_positive_wrap)
		else $error("overflow not flagged");

endmodule : phsc_counter

/* src/phsc_params.svh */
// Register offsets, field positions, reset values and limits of the counter
`ifndef PHSC_PARAMS_SVH
`define PHSC_PARAMS_SVH

`define PHSC_ADR_CTRL       8'h00
`define PHSC_ADR_CMD        8'h04
`define PHSC_ADR_STATUS     8'h08
`define PHSC_ADR_IMG_ACC    8'h0c
`define PHSC_ADR_IMG_HIGH   8'h10
`define PHSC_ADR_IMG_LOW    8'h14
`define PHSC_ADR_HW_ACC     8'h18
`define PHSC_ADR_HW_HIGH    8'h1c
`define PHSC_ADR_HW_LOW     8'h20
`define PHSC_ADR_INPUTS     8'h24

`define PHSC_CTRL_RUNG      3
`define PHSC_CTRL_IE        4
`define PHSC_STAT_ARMED     9
`define PHSC_STAT_FAULTED   10
`define PHSC_STAT_CODE_LSB  16

`define PHSC_IN_COUNT       0
`define PHSC_IN_DIR         1
`define PHSC_IN_RESET       2
`define PHSC_IN_HOLD        3

`define PHSC_FAULT_PRESETS  8'h37
`define PHSC_FAULT_NONE     8'h00
`define PHSC_ACC_MAX        16'h7fff
`define PHSC_ACC_MIN        16'h8000
`define PHSC_UP_HIGH_MIN    16'h0001
`define PHSC_WORD_RST       16'h0000

`endif

/* src/phsc_pkg.sv */
// Types shared by the counter modules
package phsc_pkg;

	typedef enum logic [2:0] {
		PHSC_UP     = 3'h0,
		PHSC_UP_RH  = 3'h1,
		PHSC_PD     = 3'h2,
		PHSC_PD_RH  = 3'h3,
		PHSC_UD     = 3'h4,
		PHSC_UD_RH  = 3'h5
	} phsc_mode_t;

	typedef enum logic [1:0] {
		PHSC_UNCONF  = 2'h0,
		PHSC_ARMED   = 2'h1,
		PHSC_FAULTED = 2'h3
	} phsc_state_t;

	typedef struct packed {
		logic cause_negative_wrap;
		logic cause_positive_wrap;
		logic cause_low_target;
		logic cause_high_target;
		logic low_target_flag;
		logic high_target_flag;
		logic negative_wrap_flag;
		logic positive_wrap_flag;
		logic done_flag;
	} phsc_flags_t;

	typedef struct packed {
		logic load_limits_instr;
		logic load_accumulator_instr;
		logic counter_clear_instr;
		logic counter_config_instr;
	} phsc_cmd_t;

endpackage : phsc_pkg

/* src/phsc_edge_sync.sv */
// Field input synchroniser and off-to-on edge detector
`timescale 1ns/10ps
module phsc_edge_sync (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [3:0] fieldIn,
	output logic      [3:0] levels,
	output logic      [3:0] rises
);
	logic [3:0] meta_reg;
	logic [3:0] sync_reg;
	logic [3:0] prev_reg;

	// Two stages, then one more sample for the edge compare
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_reg <= 4'h0;
			sync_reg <= 4'h0;
			prev_reg <= 4'h0;
		end else begin
			meta_reg <= fieldIn;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Edge is the current sample high and the previous one low
	assign levels = sync_reg;
	assign rises  = sync_reg & ~prev_reg;

	default clocking cbEdge @(posedge ref_clk); endclocking
	default disable iff (rst);

	// One count edge pulse per synchronised rise of the count input, whatever the pulse width
	chk_edge_once: assert property (
		rises[0] == $rose(levels[0]))
		else $error("count edge not seen exactly once");

endmodule : phsc_edge_sync

/* verif/phsc_field_src.sv */
// Field pulse source model for the counter's four field inputs
`timescale 1ns/10ps
module phsc_field_src (
	input  wire logic       ref_clk,
	output logic      [3:0] fieldIn
);
	initial fieldIn = 4'h0;

	// Clean off-to-on pulse, long enough to pass the two-flop synchroniser
	task automatic pulse(input int b);
		fieldIn[b] <= 1'h1;
		repeat (3) @(posedge ref_clk);
		fieldIn[b] <= 1'h0;
		repeat (5) @(posedge ref_clk);
	endtask : pulse

	// Steady level for direction and hold inputs
	task automatic level(input int b, input logic v);
		fieldIn[b] <= v;
		@(posedge ref_clk);
	endtask : level
endmodule : phsc_field_src

/* verif/phsc_counter_tb.sv */
// Self-checking bench of the preset high-speed counter
`timescale 1ns/10ps
`include "phsc_params.svh"
module phsc_counter_tb;
	localparam logic [31:0] ALL  = 32'hffffffff;
	localparam logic [31:0] FLT  = 32'h00ff0400;
	localparam logic [7:0]  HACC = `PHSC_ADR_HW_ACC;
	localparam logic [7:0]  HHI  = `PHSC_ADR_HW_HIGH;
	localparam logic [7:0]  STA  = `PHSC_ADR_STATUS;
	localparam logic [7:0]  CMD  = `PHSC_ADR_CMD;
	localparam logic [7:0]  IHI  = `PHSC_ADR_IMG_HIGH;
	localparam logic [7:0]  IACC = `PHSC_ADR_IMG_ACC;
	logic        ref_clk;
	logic        rst;
	logic [3:0]  fieldIn;
	logic        wbCyc;
	logic        wbStb;
	logic        wbWe;
	logic [7:0]  wbAdr;
	logic [31:0] wbDat;
	logic        wbAck;
	logic [31:0] wbRd;
	logic        intReq;
	int          n_errors;
	int          comparisons;
	int          irqCnt;
	int          v;

	phsc_counter i_phsc_counter (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.fieldIn  (fieldIn),
		.wb_cyc_i (wbCyc),
		.wb_stb_i (wbStb),
		.wb_we_i  (wbWe),
		.wb_adr_i (wbAdr),
		.wb_dat_i (wbDat),
		.wb_sel_i (4'hf),
		.wb_ack_o (wbAck),
		.wb_dat_o (wbRd),
		.intReq   (intReq)
	);

	phsc_field_src i_phsc_field_src (
		.ref_clk (ref_clk),
		.fieldIn (fieldIn)
	);

	// 25 MHz clock
	initial begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Counts routine requests since the last reset
	always @(posedge ref_clk) begin
		if (rst)
			irqCnt <= 0;
		else if (intReq === 1'h1)
			irqCnt <= irqCnt + 1;
	end

	task automatic stop_test();
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// One classic cycle; read data is taken at the edge that shows ack
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		wbCyc <= 1'h1;
		wbStb <= 1'h1;
		wbWe  <= w;
		wbAdr <= a;
		wbDat <= d;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (wbAck !== 1'h1 && k < 20);
		if (wbAck !== 1'h1) begin
			n_errors++;
			stop_test();
		end
		q = wbRd;
		wbCyc <= 1'h0;
		wbStb <= 1'h0;
		@(posedge ref_clk);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		wb(1'h1, a, {16'h0000, d}, q);
	endtask : wr

	// Register read compared under a mask
	task automatic chk(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [31:0] m);
		logic [31:0] q;
		wb(1'h0, a, 32'h00000000, q);
		comparisons++;
		if ((q & m) !== (e & m)) begin
			n_errors++;
			$display("wrong value %s exp %h got %h", nm, e, q);
		end
	endtask : chk

	task automatic chkw(input string nm, input logic [7:0] a,
		input logic [15:0] e);
		chk(nm, a, {16'h0000, e}, ALL);
	endtask : chkw

	task automatic chkIrq(input int e);
		comparisons++;
		if (irqCnt != e) begin
			n_errors++;
			$display("wrong value irq count exp %0d got %0d", e, irqCnt);
		end
	endtask : chkIrq

	task automatic rstDut();
		rst <= 1'h1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
	endtask : rstDut

	task automatic pls(input int b, input int n);
		repeat (n) i_phsc_field_src.pulse(b);
	endtask : pls

	// Images then configure; instructions only reach hardware registers
	task automatic cfg(input logic [2:0] m, input logic [15:0] a,
		input logic [15:0] h, input logic [15:0] l);
		wr(`PHSC_ADR_CTRL, {12'h000, 1'h1, m});
		wr(IACC, a);
		wr(IHI, h);
		wr(`PHSC_ADR_IMG_LOW, l);
		wr(CMD, 16'h0001);
	endtask : cfg

	// Watchdog for the whole run
	initial begin
		repeat (100000) @(posedge ref_clk);
		n_errors++;
		stop_test();
	end

	// Main sequence
	initial begin
		rst <= 1'h1;
		wbCyc <= 1'h0;
		wbStb <= 1'h0;
		wbWe <= 1'h0;
		wbAdr <= 8'h00;
		wbDat <= 32'h00000000;
		rstDut();
		chkw("reset acc", HACC, 16'h0000);
		wr(8'h3c, 16'h1234);
		chkw("unmapped", 8'h3c, 16'h0000);
		// Up mode: count, reach, deferred preset, wrap cause, clear, fault
		cfg(3'h0, 16'h0000, 16'h0003, 16'h0000);
		chkw("hw high", HHI, 16'h0003);
		pls(0, 2);
		chkw("acc", HACC, 16'h0002);
		wr(IHI, 16'h0002);
		chkw("hw high", HHI, 16'h0003);
		pls(0, 1);
		chkw("acc", HACC, 16'h0000);
		chkw("hw high", HHI, 16'h0002);
		chk("stat", STA, 32'h00000021, 32'h000001e7);
		chkIrq(1);
		pls(0, 2);
		chk("stat", STA, 32'h00000083, 32'h000001e7);
		chkIrq(2);
		pls(0, 1);
		wr(CMD, 16'h0002);
		chkw("acc", HACC, 16'h0000);
		wr(IHI, 16'h0000);
		wr(CMD, 16'h0002);
		chk("fault", STA, 32'h00370400, FLT);
		// Up mode with hold, external reset and false rung
		rstDut();
		cfg(3'h1, 16'h0000, 16'h0064, 16'h0000);
		pls(0, 2);
		i_phsc_field_src.level(3, 1'h1);
		pls(0, 1);
		chkw("acc", HACC, 16'h0002);
		i_phsc_field_src.level(3, 1'h0);
		pls(2, 1);
		chkw("acc", HACC, 16'h0000);
		// One count with the rung true, then none with it false
		pls(0, 1);
		wr(`PHSC_ADR_CTRL, 16'h0011);
		pls(0, 1);
		chkw("acc", HACC, 16'h0001);
		// Pulse and direction: high reach, both wraps, loads
		rstDut();
		cfg(3'h2, 16'h7ffe, 16'h7fff, 16'h0000);
		pls(0, 1);
		chkw("acc", HACC, 16'h7fff);
		chkw("hw high", HHI, 16'h7fff);
		chk("stat", STA, 32'h00000028, 32'h000001e8);
		pls(0, 1);
		chkw("acc", HACC, 16'h8000);
		chk("stat", STA, 32'h00000002, 32'h00000002);
		i_phsc_field_src.level(1, 1'h1);
		pls(0, 1);
		chkw("acc", HACC, 16'h7fff);
		chk("stat", STA, 32'h00000004, 32'h00000004);
		wr(STA, 16'h001f);
		wr(IACC, 16'h8000);
		wr(CMD, 16'h0004);
		chkw("acc", HACC, 16'h8000);
		chk("stat", STA, 32'h00000050, 32'h000001f8);
		wr(`PHSC_ADR_CTRL, 16'h000a);
		v = irqCnt;
		wr(IACC, 16'h7fff);
		wr(CMD, 16'h0004);
		chk("stat", STA, 32'h00000008, 32'h00000008);
		chkIrq(v);
		// Up/down: bad presets, then down count and clear
		rstDut();
		i_phsc_field_src.level(1, 1'h0);
		cfg(3'h4, 16'h0000, 16'h0005, 16'h0005);
		chk("fault", STA, 32'h00370400, FLT);
		wr(`PHSC_ADR_IMG_LOW, 16'hfff0);
		wr(CMD, 16'h0001);
		pls(1, 1);
		chkw("acc", HACC, 16'hffff);
		wr(CMD, 16'h0002);
		chkw("acc", HACC, 16'h0000);
		// Up/down with reset and hold: a held down edge is lost
		wr(`PHSC_ADR_CTRL, 16'h000d);
		i_phsc_field_src.level(3, 1'h1);
		pls(1, 1);
		chkw("inputs", `PHSC_ADR_INPUTS, 16'h0008);
		chkw("acc", HACC, 16'h0000);
		stop_test();
	end
endmodule : phsc_counter_tb
